/* File: hw/pmic_supervisor_pkg.sv */
// Constants shared by the supervisory control block
package pmic_supervisor_pkg;
	// Register indices on the serial port
	localparam logic [6:0] ADDR_ID = 7'h00;
	localparam logic [6:0] ADDR_ENABLE = 7'h01;
	localparam logic [6:0] ADDR_UNDERVOLTAGE_LOCKOUT = 7'h09;
	localparam logic [6:0] ADDR_INT = 7'h0C;
	localparam logic [6:0] ADDR_MASK = 7'h0D;
	localparam logic [6:0] ADDR_TIMING = 7'h0E;
	localparam logic [6:0] ADDR_KEY = 7'h10;
	localparam logic [6:0] ADDR_PROT_LO = 7'h11;
	localparam logic [6:0] ADDR_PROT_HI = 7'h27;
	localparam logic [6:0] ADDR_TOP = 7'h7F;
	// Unlock keys and key-register readback
	localparam logic [7:0] KEY_FIRST = 8'hBA;
	localparam logic [7:0] KEY_SECOND = 8'hBE;
	localparam logic [7:0] KEY_LOCKED = 8'h00;
	localparam logic [7:0] KEY_OPEN = 8'h01;
	// Arbitrary identification value
	localparam logic [7:0] CHIP_ID_VAL = 8'h5A;
	// Reset values and lockout threshold ceiling
	localparam logic [7:0] ENABLE_RST = 8'h0F;
	localparam logic [7:0] MASK_RST = 8'hDF;
	localparam logic [7:0] TIMING_RST = 8'h07;
	localparam logic [4:0] UNDERVOLTAGE_LOCKOUT_RST = 5'h00;
	localparam logic [4:0] UNDERVOLTAGE_LOCKOUT_MAX = 5'h1E;
	// Enable register fields
	localparam int EN_DISPLAY = 1;
	localparam int EN_LED = 0;
	// Interrupt register fields
	localparam int IRQ_HOT = 0;
	localparam int IRQ_TSD = 1;
	localparam int IRQ_BAT = 2;
	localparam int IRQ_UNDERVOLTAGE_LOCKOUT = 3;
	localparam int IRQ_REG = 4;
	localparam int IRQ_PG6 = 5;
	localparam int IRQ_OVP = 6;
	localparam int IRQ_LOGIC = 7;
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int PARK_MAX_US = 100;
	localparam int PARK_STEP_CYC = (PARK_MAX_US * CLK_MHZ) / 7;
	localparam int REASSERT_US = 32;
	localparam int REASSERT_CYC = REASSERT_US * CLK_MHZ;
	localparam int REASSERT_RUN = 64;
	typedef enum logic [1:0] {
		PWR_STANDBY = 2'b00,
		PWR_ACTIVE = 2'b01,
		PWR_PARK = 2'b10,
		PWR_DISCHARGE = 2'b11
	} pwr_state_t;
endpackage : pmic_supervisor_pkg

/* File: hw/level_sync.sv */
// Two-flop synchroniser for a bank of levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_b_i, // Async reset, low
	input wire logic [WIDTH-1:0] d_i, // Asynchronous levels
	input wire logic [WIDTH-1:0] rst_val_i, // Unused-at-reset marker
	output logic [WIDTH-1:0] q_o // Synchronised levels
);
	logic [WIDTH-1:0] meta;
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					meta[g] <= 1'b0;
					q_o[g] <= 1'b0;
				end else begin
					meta[g] <= d_i[g];
					q_o[g] <= meta[g];
				end
			end
		end
	endgenerate
	logic unused;
	assign unused = ^rst_val_i;
endmodule : level_sync
`default_nettype wire

/* File: hw/serial_port.sv */
// Serial register port: framing, shifting, auto-increment
`timescale 1ns/1ps
`default_nettype none
module serial_port (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_b_i, // Async reset, low
	input wire logic enable_i, // Port allowed to respond
	input wire logic sel_n_i, // Synced chip select, low
	input wire logic sclk_i, // Synced serial clock
	input wire logic din_i, // Synced serial data in
	input wire logic [7:0] rdata_i, // Read data at addr_o
	output logic [6:0] addr_o, // Current register address
	output logic [7:0] wdata_o, // Write data byte
	output logic wr_o, // Write strobe, one cycle
	output logic rd_o, // Read strobe, one cycle
	output logic frame_end_o, // Select rose, one cycle
	output logic dout_o, // Serial data out
	output logic dout_oe_o // Serial data out enable
);
	logic sclk_d;
	logic sel_d;
	logic [2:0] bitcnt;
	logic [7:0] shreg;
	logic [7:0] txreg;
	logic have_cmd;
	logic is_write;
	logic rise;
	logic fall;
	logic active;
	assign active = enable_i && !sel_n_i;
	assign rise = sclk_i && !sclk_d;
	assign fall = !sclk_i && sclk_d;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sclk_d <= 1'b0;
			sel_d <= 1'b1;
		end else begin
			sclk_d <= sclk_i;
			sel_d <= sel_n_i;
		end
	end
	// Receive side: sample on rising edge
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bitcnt <= 3'h0;
			shreg <= 8'h00;
			have_cmd <= 1'b0;
			is_write <= 1'b0;
			addr_o <= 7'h00;
			wdata_o <= 8'h00;
			wr_o <= 1'b0;
			rd_o <= 1'b0;
		end else begin
			wr_o <= 1'b0;
			rd_o <= 1'b0;
			if (wr_o) begin
				addr_o <= addr_o + 7'h01;
			end
			if (!active) begin
				bitcnt <= 3'h0;
				have_cmd <= 1'b0;
			end else if (rise) begin
				shreg <= {shreg[6:0], din_i};
				bitcnt <= bitcnt + 3'h1;
				if (bitcnt == 3'h7) begin
					if (!have_cmd) begin
						have_cmd <= 1'b1;
						is_write <= shreg[6];
						addr_o <= {shreg[5:0], din_i};
						rd_o <= !shreg[6];
					end else if (is_write) begin
						// Write lands first, address steps after
						wdata_o <= {shreg[6:0], din_i};
						wr_o <= 1'b1;
					end else begin
						// Step before the strobe so the next byte preloads
						addr_o <= addr_o + 7'h01;
						rd_o <= 1'b1;
					end
				end
			end
		end
	end
	// Transmit side: shift on falling edge
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			txreg <= 8'h00;
			dout_o <= 1'b0;
			dout_oe_o <= 1'b0;
			frame_end_o <= 1'b0;
		end else begin
			frame_end_o <= sel_n_i && !sel_d;
			dout_oe_o <= active;
			if (rd_o) begin
				txreg <= rdata_i;
			end else if (active && fall && have_cmd && !is_write) begin
				dout_o <= txreg[7];
				txreg <= {txreg[6:0], 1'b0};
			end
			if (!active) begin
				dout_o <= 1'b0;
			end
		end
	end
	a_sel_float: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		!active |=> !dout_oe_o)
		else $error("data output driven while deselected");
endmodule : serial_port
`default_nettype wire

/* File: hw/pmic_fault_irq_spi_ctrl.sv */
// Fault supervision, interrupt register and register file
`timescale 1ns/1ps
`default_nettype none
module pmic_fault_irq_spi_ctrl #(
	parameter int PARK_STEP = pmic_supervisor_pkg::PARK_STEP_CYC,
	parameter int REASSERT = pmic_supervisor_pkg::REASSERT_CYC,
	parameter int PROT_REGS = 23
) (
	input wire logic clk_sys_i, // System clock 200 MHz
	input wire logic rst_b_i, // Async reset, low
	input wire logic projector_on_pin_i, // Projector on pin
	input wire logic hot_i, // Die above warning
	input wire logic tsd_i, // Die above shutdown
	input wire logic low_battery_event_i, // Battery below warning
	input wire logic undervoltage_lockout_i, // Battery below lockout
	input wire logic uv_recovered_i, // Input above recovery
	input wire logic reg_fault_i, // Mirror regulator fault
	input wire logic aux_pg_fail_i, // Aux rail not good
	input wire logic led_ovp_i, // LED supply overvoltage
	input wire logic logic_fail_i, // Switched output failed
	input wire logic serial_select_n_i, // Chip select, low
	input wire logic sclk_i, // Serial clock
	input wire logic din_i, // Serial data in
	output logic dout_o, // Serial data out
	output logic dout_oe_o, // Serial data out enable
	output logic irq_out_n_o, // Interrupt pin level, low
	output logic irq_out_n_oe_o, // Interrupt pin drive enable
	output logic mirror_en_o, // Mirror regulators enable
	output logic led_en_o, // LED converter enable
	output logic mirror_discharge_o, // Fast discharge mirror rails
	output logic [4:0] undervoltage_lockout_thresh_o, // Lockout threshold code
	output logic standby_o // Standby or discharge state
);
	localparam int NSYNC = 13;
	logic [NSYNC-1:0] sraw;
	logic [NSYNC-1:0] s;
	assign sraw = {projector_on_pin_i, hot_i, tsd_i, low_battery_event_i, undervoltage_lockout_i,
		uv_recovered_i, reg_fault_i, aux_pg_fail_i, led_ovp_i,
		logic_fail_i, serial_select_n_i, sclk_i, din_i};
	level_sync #(.WIDTH(NSYNC)) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.d_i(sraw),
		.rst_val_i('0),
		.q_o(s)
	);
	logic pon;
	logic [7:0] cond;
	logic uv_rec;
	logic sel_n;
	logic sck;
	logic sdi;
	assign pon = s[12];
	assign cond = {s[3], s[4], s[5], s[6], s[8], s[9], s[10], s[11]};
	assign uv_rec = s[7];
	assign sel_n = s[2];
	assign sck = s[1];
	assign sdi = s[0];

	// Counters are 16 and 13 bits wide
	if (PARK_STEP < 1 || PARK_STEP * 7 > 65535 || REASSERT < 1 ||
		REASSERT > 8192 || PROT_REGS != 23) begin : g_bad_params
		$error("pmic_fault_irq_spi_ctrl: bad parameters");
	end

	// ------------------------------------------------------------
	// Serial port
	// ------------------------------------------------------------
	logic [6:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic frame_end;
	logic [7:0] rdata;
	serial_port u_port (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.enable_i(pon),
		.sel_n_i(sel_n),
		.sclk_i(sck),
		.din_i(sdi),
		.rdata_i(rdata),
		.addr_o(addr),
		.wdata_o(wdata),
		.wr_o(wr),
		.rd_o(rd),
		.frame_end_o(frame_end),
		.dout_o(dout_o),
		.dout_oe_o(dout_oe_o)
	);

	// ------------------------------------------------------------
	// Registers and key lock
	// ------------------------------------------------------------
	logic [7:0] enable_reg;
	logic [7:0] mask;
	logic [7:0] timing;
	logic [7:0] irq;
	logic [7:0] prot [PROT_REGS];
	logic unlocked;
	logic key_armed;
	logic prot_hit;
	logic [4:0] prot_idx;
	logic fault_clr_en;
	logic irq_rd;
	assign prot_hit = addr >= pmic_supervisor_pkg::ADDR_PROT_LO &&
		addr <= pmic_supervisor_pkg::ADDR_PROT_HI;
	assign prot_idx = 5'(addr - pmic_supervisor_pkg::ADDR_PROT_LO);
	assign irq_rd = rd && addr == pmic_supervisor_pkg::ADDR_INT;

	// Key sequence; any other access between keys disarms
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			unlocked <= 1'b0;
			key_armed <= 1'b0;
		end else if (!pon) begin
			key_armed <= 1'b0;
		end else if (wr && addr == pmic_supervisor_pkg::ADDR_KEY) begin
			key_armed <= wdata == pmic_supervisor_pkg::KEY_FIRST;
			if (key_armed && wdata == pmic_supervisor_pkg::KEY_SECOND) begin
				unlocked <= 1'b1;
			end else if (wdata != pmic_supervisor_pkg::KEY_FIRST) begin
				unlocked <= 1'b0;
			end
		end else if (wr || rd) begin
			key_armed <= 1'b0;
		end
	end

	// Protected store; locked writes dropped
	genvar g;
	generate
		for (g = 0; g < PROT_REGS; g++) begin : g_prot
			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					prot[g] <= 8'h00;
				end else if (!pon) begin
					prot[g] <= 8'h00;
				end else if (wr && unlocked && prot_hit &&
					prot_idx == 5'(g)) begin
					prot[g] <= wdata;
				end
			end
			a_prot_locked: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				pon && wr && !unlocked ##1 pon |-> $stable(prot[g]))
				else $error("protected register written while locked");
		end
	endgenerate

	logic display_clr;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			enable_reg <= pmic_supervisor_pkg::ENABLE_RST &
				~(8'h01 << pmic_supervisor_pkg::EN_DISPLAY);
			mask <= pmic_supervisor_pkg::MASK_RST;
			timing <= pmic_supervisor_pkg::TIMING_RST;
			undervoltage_lockout_thresh_o <= pmic_supervisor_pkg::UNDERVOLTAGE_LOCKOUT_RST;
		end else if (!pon) begin
			// Display enable defaults to zero at power-on
			enable_reg <= pmic_supervisor_pkg::ENABLE_RST &
				~(8'h01 << pmic_supervisor_pkg::EN_DISPLAY);
			mask <= pmic_supervisor_pkg::MASK_RST;
			timing <= pmic_supervisor_pkg::TIMING_RST;
			undervoltage_lockout_thresh_o <= pmic_supervisor_pkg::UNDERVOLTAGE_LOCKOUT_RST;
		end else begin
			if (wr) begin
				case (addr)
					pmic_supervisor_pkg::ADDR_ENABLE: enable_reg <= wdata;
					pmic_supervisor_pkg::ADDR_MASK: mask <= wdata;
					pmic_supervisor_pkg::ADDR_TIMING: timing <= wdata;
					pmic_supervisor_pkg::ADDR_UNDERVOLTAGE_LOCKOUT: begin
						// 31 codes, saturate
						undervoltage_lockout_thresh_o <= (wdata[4:0] >
							pmic_supervisor_pkg::UNDERVOLTAGE_LOCKOUT_MAX) ?
							pmic_supervisor_pkg::UNDERVOLTAGE_LOCKOUT_MAX : wdata[4:0];
					end
					default: ;
				endcase
			end
			if (display_clr) begin
				enable_reg[pmic_supervisor_pkg::EN_DISPLAY] <= 1'b0;
			end
		end
	end

	always_comb begin
		rdata = 8'h00;
		case (addr)
			pmic_supervisor_pkg::ADDR_ID: rdata = pmic_supervisor_pkg::CHIP_ID_VAL;
			pmic_supervisor_pkg::ADDR_ENABLE: rdata = enable_reg;
			pmic_supervisor_pkg::ADDR_UNDERVOLTAGE_LOCKOUT: rdata = {3'h0, undervoltage_lockout_thresh_o};
			pmic_supervisor_pkg::ADDR_INT: rdata = irq;
			pmic_supervisor_pkg::ADDR_MASK: rdata = mask;
			pmic_supervisor_pkg::ADDR_TIMING: rdata = timing;
			pmic_supervisor_pkg::ADDR_KEY: rdata = unlocked ?
				pmic_supervisor_pkg::KEY_OPEN :
				pmic_supervisor_pkg::KEY_LOCKED;
			default: rdata = prot_hit ? prot[prot_idx] : 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Interrupt register and pin
	// ------------------------------------------------------------
	logic [7:0] cond_d;
	logic [7:0] rise_ev;
	logic [12:0] reassert_cnt;
	logic reassert;
	assign rise_ev = cond & ~cond_d;
	assign reassert = reassert_cnt == 13'(REASSERT - 1);
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cond_d <= 8'h00;
			reassert_cnt <= 13'h0000;
		end else begin
			cond_d <= cond;
			// Restart on a read so a persisting fault reappears in time
			reassert_cnt <= (reassert || irq_rd) ? 13'h0000 :
				reassert_cnt + 13'h0001;
		end
	end
	// Set wins over the read clear; persisting faults re-set
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq <= 8'h00;
		end else if (!pon) begin
			irq <= 8'h00;
		end else begin
			irq <= (irq & ~(irq_rd ? 8'hFF : 8'h00)) | rise_ev |
				(reassert ? cond : 8'h00);
		end
	end
	// Mask affects the pin and the regulator restart lock, not the register bits
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_out_n_o <= 1'b0;
			irq_out_n_oe_o <= 1'b0;
		end else begin
			irq_out_n_o <= 1'b0;
			irq_out_n_oe_o <= pon && |(irq & ~mask);
		end
	end
	a_irq_pin_gate: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		irq_out_n_oe_o |-> $past(pon) && $past(|(irq & ~mask)))
		else $error("interrupt pin driven without unmasked bit");
	a_irq_set: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		pon |=> (irq & $past(rise_ev)) == $past(rise_ev))
		else $error("event did not set its interrupt bit");
	a_irq_read_clr: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		pon && irq_rd && rise_ev == 8'h00 && !reassert |=> irq == 8'h00)
		else $error("interrupt read did not clear bits");

	// ------------------------------------------------------------
	// Power sequencing
	// ------------------------------------------------------------
	pmic_supervisor_pkg::pwr_state_t state;
	pmic_supervisor_pkg::pwr_state_t next_state;
	logic [15:0] park_cnt;
	logic [15:0] park_len;
	logic shut_now;
	logic uv_lock;
	logic reg_lock;
	logic logic_lock;
	logic go;
	assign park_len = 16'(int'(timing[2:0]) * PARK_STEP);
	// Battery warning and LED overvoltage never shut rails
	assign shut_now = cond[pmic_supervisor_pkg::IRQ_TSD] ||
		cond[pmic_supervisor_pkg::IRQ_REG] ||
		cond[pmic_supervisor_pkg::IRQ_LOGIC];
	assign display_clr = cond[pmic_supervisor_pkg::IRQ_TSD] ||
		cond[pmic_supervisor_pkg::IRQ_REG] ||
		cond[pmic_supervisor_pkg::IRQ_UNDERVOLTAGE_LOCKOUT];
	assign go = pon && enable_reg[pmic_supervisor_pkg::EN_DISPLAY] &&
		!uv_lock && !reg_lock && !logic_lock && uv_rec && !shut_now &&
		!cond[pmic_supervisor_pkg::IRQ_UNDERVOLTAGE_LOCKOUT];
	// Restart locks, released only by the projector-on pin
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			uv_lock <= 1'b0;
			reg_lock <= 1'b0;
			logic_lock <= 1'b0;
		end else if (!pon) begin
			uv_lock <= 1'b0;
			reg_lock <= 1'b0;
			logic_lock <= 1'b0;
		end else begin
			if (cond[pmic_supervisor_pkg::IRQ_UNDERVOLTAGE_LOCKOUT]) begin
				uv_lock <= 1'b1;
			end
			if (cond[pmic_supervisor_pkg::IRQ_REG] &&
				!mask[pmic_supervisor_pkg::IRQ_REG]) begin
				reg_lock <= 1'b1;
			end
			if (cond[pmic_supervisor_pkg::IRQ_LOGIC]) begin
				logic_lock <= 1'b1;
			end
		end
	end
	always_comb begin
		next_state = state;
		case (state)
			pmic_supervisor_pkg::PWR_STANDBY: begin
				if (go) begin
					next_state = pmic_supervisor_pkg::PWR_ACTIVE;
				end
			end
			pmic_supervisor_pkg::PWR_ACTIVE: begin
				if (shut_now) begin
					next_state = pmic_supervisor_pkg::PWR_DISCHARGE;
				end else if (cond[pmic_supervisor_pkg::IRQ_UNDERVOLTAGE_LOCKOUT]) begin
					next_state = pmic_supervisor_pkg::PWR_PARK;
				end else if (!enable_reg[pmic_supervisor_pkg::EN_DISPLAY]) begin
					next_state = pmic_supervisor_pkg::PWR_STANDBY;
				end
			end
			pmic_supervisor_pkg::PWR_PARK: begin
				if (shut_now || park_cnt >= park_len) begin
					next_state = pmic_supervisor_pkg::PWR_DISCHARGE;
				end
			end
			pmic_supervisor_pkg::PWR_DISCHARGE: begin
				if (go) begin
					next_state = pmic_supervisor_pkg::PWR_STANDBY;
				end
			end
			default: next_state = pmic_supervisor_pkg::PWR_STANDBY;
		endcase
		if (!pon) begin
			next_state = pmic_supervisor_pkg::PWR_STANDBY;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= pmic_supervisor_pkg::PWR_STANDBY;
			park_cnt <= 16'h0000;
		end else begin
			state <= next_state;
			if (state == pmic_supervisor_pkg::PWR_PARK) begin
				park_cnt <= park_cnt + 16'h0001;
			end else begin
				park_cnt <= 16'h0000;
			end
		end
	end
	// Rail controls follow the next state
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mirror_en_o <= 1'b0;
			led_en_o <= 1'b0;
			mirror_discharge_o <= 1'b0;
			standby_o <= 1'b1;
		end else begin
			mirror_en_o <= next_state == pmic_supervisor_pkg::PWR_ACTIVE ||
				next_state == pmic_supervisor_pkg::PWR_PARK;
			led_en_o <= next_state == pmic_supervisor_pkg::PWR_ACTIVE &&
				enable_reg[pmic_supervisor_pkg::EN_LED] &&
				!cond[pmic_supervisor_pkg::IRQ_PG6];
			mirror_discharge_o <=
				next_state == pmic_supervisor_pkg::PWR_DISCHARGE;
			standby_o <= next_state == pmic_supervisor_pkg::PWR_STANDBY ||
				next_state == pmic_supervisor_pkg::PWR_DISCHARGE;
		end
	end
	a_fault_standby: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		pon && shut_now |=> !mirror_en_o && !led_en_o)
		else $error("rails left on during a fault");
	a_undervoltage_lockout_parks: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		pon && state == pmic_supervisor_pkg::PWR_ACTIVE && !shut_now &&
		cond[pmic_supervisor_pkg::IRQ_UNDERVOLTAGE_LOCKOUT] |=>
		state == pmic_supervisor_pkg::PWR_PARK)
		else $error("lockout skipped mirror parking");
	a_display_clr: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		pon && cond[pmic_supervisor_pkg::IRQ_REG] |=>
		!enable_reg[pmic_supervisor_pkg::EN_DISPLAY])
		else $error("display enable kept during regulator fault");
endmodule : pmic_fault_irq_spi_ctrl
`default_nettype wire

/* File: test/host_spi_model.sv */
// Host-side serial master model for the register port
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
	output logic sel_n_o, // Chip select, low
	output logic sclk_o, // Serial clock, idles low
	output logic din_o, // Data to device
	input wire logic dout_i, // Data from device
	input wire logic dout_oe_i // Device drives data
);
	// ------------------------------
	// Frames
	// ------------------------------
	logic last;
	logic miso;
	// Floating line shows the inverse of its last level
	assign miso = dout_oe_i ? dout_i : ~last;
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o = 1'b0;
		last = 1'b0;
	end
	task automatic frame(input logic [7:0] cmd, input int n,
		input logic [7:0] wd [2], output logic [7:0] rd [2]);
		logic [7:0] b;
		sel_n_o = 1'b0;
		for (int k = -1; k < n; k++) begin
			b = (k < 0) ? cmd : wd[k];
			for (int i = 7; i >= 0; i--) begin
				#32 sclk_o = 1'b0;
				din_o = b[i];
				#32 sclk_o = 1'b1;
				if (k >= 0)
					rd[k][i] = miso;
				last = miso;
			end
			#32 sclk_o = 1'b0;
		end
		#32 sel_n_o = 1'b1;
		#128;
	endtask : frame
endmodule : host_spi_model
`default_nettype wire

/* File: test/pmic_fault_irq_spi_ctrl_bench.sv */
// Self-checking bench for the supervisory control block
`timescale 1ns/1ps
`default_nettype none
module pmic_fault_irq_spi_ctrl_bench;
	// ------------------------------
	// Signals and instances
	// ------------------------------
	localparam int RA = 2000;
	logic clk_sys_i, rst_b_i, projector_on_pin_i, hot_i, tsd_i, low_battery_event_i;
	logic undervoltage_lockout_i, uv_recovered_i, reg_fault_i, aux_pg_fail_i, led_ovp_i;
	logic logic_fail_i, sel_n, sclk, din, dout_o, dout_oe_o, irq_out_n_o;
	logic irq_out_n_oe_o, mirror_en_o, led_en_o, mirror_discharge_o;
	logic standby_o, irq_n;
	logic [4:0] undervoltage_lockout_thresh_o;
	logic [7:0] wd [2];
	logic [7:0] rd [2];
	int num_errors, checks_done;
	// Open-drain pin with pull-up
	assign irq_n = irq_out_n_oe_o ? irq_out_n_o : 1'b1;
	pmic_fault_irq_spi_ctrl #(.PARK_STEP(10), .REASSERT(RA)) DUT (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.projector_on_pin_i(projector_on_pin_i), .hot_i(hot_i),
		.tsd_i(tsd_i), .low_battery_event_i(low_battery_event_i), .undervoltage_lockout_i(undervoltage_lockout_i),
		.uv_recovered_i(uv_recovered_i), .reg_fault_i(reg_fault_i),
		.aux_pg_fail_i(aux_pg_fail_i), .led_ovp_i(led_ovp_i),
		.logic_fail_i(logic_fail_i), .serial_select_n_i(sel_n),
		.sclk_i(sclk), .din_i(din), .dout_o(dout_o),
		.dout_oe_o(dout_oe_o), .irq_out_n_o(irq_out_n_o),
		.irq_out_n_oe_o(irq_out_n_oe_o), .mirror_en_o(mirror_en_o),
		.led_en_o(led_en_o), .mirror_discharge_o(mirror_discharge_o),
		.undervoltage_lockout_thresh_o(undervoltage_lockout_thresh_o), .standby_o(standby_o)
	);
	host_spi_model host (.sel_n_o(sel_n), .sclk_o(sclk), .din_o(din),
		.dout_i(dout_o), .dout_oe_i(dout_oe_o));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
			num_errors++;
		end
	endtask : chk
	task automatic c1(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask : c1
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : wt
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		wd[0] = d;
		host.frame({1'b1, a}, 1, wd, rd);
	endtask : wr
	task automatic rc(input logic [6:0] a, input logic [7:0] e,
		input string nm);
		host.frame({1'b0, a}, 1, wd, rd);
		chk(nm, e, rd[0]);
	endtask : rc
	task automatic wirq(input logic v);
		int i;
		i = 0;
		while (irq_n !== v && i < RA + 200) begin
			@(posedge clk_sys_i);
			i++;
		end
		c1("irq_n", v, irq_n);
		if (i >= RA + 200)
			finish_test();
	endtask : wirq
	initial begin
		wt(100000);
		num_errors++;
		finish_test();
	end
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		{hot_i, tsd_i, low_battery_event_i, undervoltage_lockout_i, reg_fault_i} = 5'h00;
		{aux_pg_fail_i, led_ovp_i, logic_fail_i} = 3'h0;
		uv_recovered_i = 1'b1;
		projector_on_pin_i = 1'b1;
		rst_b_i = 1'b0;
		num_errors = 0;
		checks_done = 0;
		wt(6);
		rst_b_i <= 1'b1;
		wt(40);
		rc(7'h0D, 8'hDF, "mask");
		rc(7'h0E, 8'h07, "timing");
		rc(7'h10, 8'h00, "key");
		rc(7'h0C, 8'h00, "int");
		rc(7'h00, pmic_supervisor_pkg::CHIP_ID_VAL, "id");
		wr(7'h09, 8'h1E);
		chk("undervoltage_lockout_thresh", 8'h1E, {3'h0, undervoltage_lockout_thresh_o});
		wd[1] = 8'h03;
		wr(7'h0D, 8'h5F);
		host.frame(8'h8D, 2, wd, rd);
		rc(7'h0D, 8'h5F, "mask");
		rc(7'h0E, 8'h03, "timing");
		host.frame(8'h7F, 2, wd, rd);
		chk("wrap", pmic_supervisor_pkg::CHIP_ID_VAL, rd[1]);
		$display("test registers done");
		wr(7'h20, 8'h55);
		rc(7'h20, 8'h00, "locked");
		wr(7'h10, 8'hBA);
		rc(7'h0D, 8'h5F, "mask");
		wr(7'h10, 8'hBE);
		rc(7'h10, 8'h00, "key");
		wr(7'h10, 8'hBA);
		wr(7'h10, 8'hBE);
		rc(7'h10, 8'h01, "key");
		wr(7'h20, 8'h55);
		wr(7'h10, 8'hBA);
		rc(7'h20, 8'h55, "open");
		wr(7'h10, 8'h00);
		rc(7'h10, 8'h00, "key");
		wr(7'h20, 8'hAA);
		rc(7'h20, 8'h55, "locked");
		$display("test lock done");
		wr(7'h0D, 8'hFF);
		@(posedge clk_sys_i);
		hot_i <= 1'b1;
		low_battery_event_i <= 1'b1;
		wt(20);
		hot_i <= 1'b0;
		low_battery_event_i <= 1'b0;
		wt(20);
		c1("irq_n", 1'b1, irq_n);
		rc(7'h0C, 8'h05, "int");
		rc(7'h0C, 8'h00, "int");
		wr(7'h0D, 8'hDB);
		low_battery_event_i <= 1'b1;
		wt(20);
		low_battery_event_i <= 1'b0;
		wirq(1'b0);
		rc(7'h0C, 8'h04, "int");
		wirq(1'b1);
		aux_pg_fail_i <= 1'b1;
		led_ovp_i <= 1'b1;
		wt(20);
		aux_pg_fail_i <= 1'b0;
		wr(7'h0D, 8'hBF);
		wirq(1'b0);
		rc(7'h0C, 8'h60, "int");
		wirq(1'b1);
		wirq(1'b0);
		led_ovp_i <= 1'b0;
		rc(7'h0C, 8'h40, "int");
		wr(7'h0D, 8'hFF);
		$display("test interrupts done");
		wr(7'h01, 8'h0F);
		wt(40);
		c1("led_en", 1'b1, led_en_o);
		led_ovp_i <= 1'b1;
		low_battery_event_i <= 1'b1;
		wt(40);
		c1("led_en", 1'b1, led_en_o);
		c1("mirror_en", 1'b1, mirror_en_o);
		led_ovp_i <= 1'b0;
		low_battery_event_i <= 1'b0;
		reg_fault_i <= 1'b1;
		wt(40);
		c1("mirror_en", 1'b0, mirror_en_o);
		c1("led_en", 1'b0, led_en_o);
		c1("standby", 1'b1, standby_o);
		reg_fault_i <= 1'b0;
		host.frame(8'h01, 1, wd, rd);
		c1("display", 1'b0, rd[0][1]);
		wr(7'h01, 8'h0F);
		wt(40);
		c1("mirror_en", 1'b1, mirror_en_o);
		tsd_i <= 1'b1;
		wt(40);
		c1("mirror_en", 1'b0, mirror_en_o);
		c1("led_en", 1'b0, led_en_o);
		tsd_i <= 1'b0;
		host.frame(8'h0C, 1, wd, rd);
		c1("tsd", 1'b1, rd[0][1]);
		wr(7'h01, 8'h0F);
		wt(40);
		c1("mirror_en", 1'b1, mirror_en_o);
		logic_fail_i <= 1'b1;
		wt(6);
		c1("discharge", 1'b1, mirror_discharge_o);
		logic_fail_i <= 1'b0;
		projector_on_pin_i <= 1'b0;
		wt(40);
		projector_on_pin_i <= 1'b1;
		wt(40);
		rc(7'h0D, 8'hDF, "mask");
		$display("test protection done");
		wr(7'h01, 8'h0F);
		wt(40);
		undervoltage_lockout_i <= 1'b1;
		uv_recovered_i <= 1'b0;
		wt(10);
		c1("discharge", 1'b0, mirror_discharge_o);
		wt(150);
		c1("discharge", 1'b1, mirror_discharge_o);
		c1("standby", 1'b1, standby_o);
		undervoltage_lockout_i <= 1'b0;
		uv_recovered_i <= 1'b1;
		host.frame(8'h01, 1, wd, rd);
		c1("display", 1'b0, rd[0][1]);
		wr(7'h01, 8'h0F);
		wt(40);
		c1("mirror_en", 1'b0, mirror_en_o);
		$display("test lockout done");
		finish_test();
	end
endmodule : pmic_fault_irq_spi_ctrl_bench
`default_nettype wire
